// ---- rtl/pic_ctl_pkg.sv ----
// Package: register map, field layout and source map of the interrupt controller
package pri_ctl_pkg;
	localparam int NSRC = 16;
	localparam int AW = 5;
	localparam int DW = 16;
	// Register offsets (word index on the plain register port)
	localparam logic [4:0] OFF_FLAGS0 = 5'h00;
	localparam logic [4:0] OFF_ENABLE0 = 5'h01;
	localparam logic [4:0] OFF_PRIO0 = 5'h02;
	localparam logic [4:0] OFF_PRIO1 = 5'h03;
	localparam logic [4:0] OFF_PRIO2 = 5'h04;
	localparam logic [4:0] OFF_PRIO3 = 5'h05;
	localparam logic [4:0] OFF_PRIO9 = 5'h06;
	localparam logic [4:0] OFF_CTRL1 = 5'h07;
	localparam logic [4:0] OFF_CTRL2 = 5'h08;
	localparam logic [4:0] OFF_REPORT = 5'h09;
	localparam logic [4:0] OFF_STATUS = 5'h0A;
	localparam logic [4:0] OFF_CORCTL = 5'h0B;
	localparam logic [4:0] OFF_EVSTAT = 5'h0C;
	localparam logic [4:0] OFF_EVEN = 5'h0D;
	localparam logic [4:0] OFF_EVCLR = 5'h0E;
	// Implemented bits of the flag/enable registers (one per source)
	localparam logic [15:0] SRC_MASK = 16'hB9CD;
	// Implemented priority bits of the four source priority registers and the gate register
	localparam logic [15:0] PRIO0_MASK = 16'h7707;
	localparam logic [15:0] PRIO1_MASK = 16'h7700;
	localparam logic [15:0] PRIO2_MASK = 16'h7007;
	localparam logic [15:0] PRIO3_MASK = 16'h7077;
	localparam logic [15:0] PRIO9_MASK = 16'h0070;
	localparam logic [15:0] PRIO_RST = 16'h4444;
	localparam logic [15:0] PRIO9_RST = 16'h0040;
	// Gate source index and field
	localparam int GATE_SRC = 1;
	localparam int GATE_LSB = 4;
	// Control fields
	localparam int NEST_DIS_BIT = 15;
	localparam int ALT_VEC_BIT = 15;
	localparam logic [15:0] CTRL1_MASK = 16'h801F;
	localparam logic [15:0] CTRL2_MASK = 16'h8007;
	localparam int IPL_LSB = 5;
	localparam int IPL_TOP_BIT = 3;
	localparam int VEC_LSB = 0;
	localparam int LVL_LSB = 8;
	localparam int VEC_W = 7;
	localparam int LVL_W = 4;
	localparam int PRIO_W = 3;
	// Event status bits
	localparam int EV_NEW = 0;
	localparam int EV_FLAG = 1;
	localparam int EV_W = 2;
	typedef enum logic [2:0] {
		PRI_IDLE = 3'b001,
		PRI_PEND = 3'b010,
		PRI_ACK = 3'b100
	} pri_state_t;
endpackage

// ---- rtl/pic_prio_cmp.sv ----
// One step of the priority tournament between two candidates
`timescale 1ns/1ps
module pri_prio_cmp
	import pri_ctl_pkg::*;
(
	// Left candidate, lower vector
	input wire logic a_vld,
	input wire logic [2:0] a_lvl,
	input wire logic [6:0] a_vec,
	// Right candidate
	input wire logic b_vld,
	input wire logic [2:0] b_lvl,
	input wire logic [6:0] b_vec,
	// Winner
	output logic w_vld,
	output logic [2:0] w_lvl,
	output logic [6:0] w_vec
);
	logic take_b;
	// Equal levels keep the lower vector
	assign take_b = b_vld && (!a_vld || (b_lvl > a_lvl)); // RL13
	assign w_vld = a_vld || b_vld;
	assign w_lvl = take_b ? b_lvl : a_lvl;
	assign w_vec = take_b ? b_vec : a_vec;
endmodule

// ---- rtl/pic_ctl.sv ----
// Prioritized interrupt controller: flags, enables, priorities and vector report
// Summary of operation
// RL1: Each source has a flag set by its request input and cleared only by software.
// RL2: A source with its enable clear is never offered, but its flag still sets.
// RL3: Each source has its own priority field that software sets to any of eight levels.
// RL4: Priority 7 is highest, 1 lowest, and 0 disables the source.
// RL5: The pending vector and its level are latched into a 7-bit and a 4-bit report field.
// RL6: The reported new level equals the programmed priority of the pending source.
// RL7: Sources map in vector order; source 0 is bit 0 and priority bits 2:0 of the first register.
// RL8: Status bits 7:5 hold the lower current level bits and software may rewrite them.
// RL9: A fourth level bit in the core control register is read-only to software.
// RL10: The first control register holds the nesting disable and trap flags.
// RL11: The second control register sets external request behaviour and alternate vectors.
// RL12: The gate source priority lives in bits 6-4 of its register; other bits read zero.
// RL13: A source is offered only if flagged, enabled and above the current level; ties go low.
// RL14: Unimplemented flag, enable and priority bits ignore writes and read zero.
`timescale 1ns/1ps
module pri_ctl
	import pri_ctl_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Register port
	input wire logic [pri_ctl_pkg::AW-1:0] reg_addr,
	input wire logic [pri_ctl_pkg::DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [pri_ctl_pkg::DW-1:0] reg_rdata,
	// Request sources, from pins or other clocks
	input wire logic [pri_ctl_pkg::NSRC-1:0] irq_src,
	// Core side
	input wire logic cpu_ack,
	input wire logic trap_active,
	output logic irq_req,
	output logic [6:0] irq_vec,
	output logic [3:0] irq_lvl,
	output logic alt_vec_sel,
	output logic [2:0] ext_edge_sel,
	output logic irq_out
);
	import pri_ctl_pkg::*;

	logic [NSRC-1:0] src_meta_reg, src_sync_reg, src_prev_reg;
	logic [15:0] flags_reg, enable_reg;
	logic [15:0] prio_reg [0:3];
	logic [15:0] prio9_reg;
	logic [15:0] ctrl1_reg, ctrl2_reg;
	logic [2:0] ipl_reg;
	logic ipl_top_reg;
	logic [VEC_W-1:0] vec_reg;
	logic [LVL_W-1:0] lvl_reg;
	logic [EV_W-1:0] ev_stat_reg, ev_en_reg;
	pri_state_t state_reg;
	logic [NSRC-1:0] src_rise, src_event;
	logic [2:0] src_lvl [0:NSRC-1];
	logic [3:0] cur_lvl;
	logic [NSRC-1:0] cand;
	logic win_vld;
	logic [2:0] win_lvl;
	logic [6:0] win_vec;
	logic wr_flags;
	logic [EV_W-1:0] ev_set;

	// Requests come from foreign domains: two-stage sync first
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			src_meta_reg <= '0;
			src_sync_reg <= '0;
			src_prev_reg <= '0;
		end else begin
			src_meta_reg <= irq_src;
			src_sync_reg <= src_meta_reg;
			src_prev_reg <= src_sync_reg;
		end
	end

	// External pins 0, 2 and 4 may choose falling edge through the second control
	always_comb begin
		src_rise = src_sync_reg & ~src_prev_reg;
		src_event = src_rise;
		src_event[0] = ctrl2_reg[0] ? (src_prev_reg[0] & ~src_sync_reg[0])
			: src_rise[0]; // RL11
		src_event[2] = ctrl2_reg[1] ? (src_prev_reg[2] & ~src_sync_reg[2])
			: src_rise[2]; // RL11
		src_event[4] = ctrl2_reg[2] ? (src_prev_reg[4] & ~src_sync_reg[4])
			: src_rise[4]; // RL11
		src_event = src_event & SRC_MASK;
	end

	assign wr_flags = reg_wr && (reg_addr == OFF_FLAGS0);

	// Set wins over a software clear in the same cycle
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_reg <= '0;
		end else if (wr_flags) begin
			flags_reg <= ((flags_reg & reg_wdata) | src_event) & SRC_MASK; // RL1
		end else begin
			flags_reg <= (flags_reg | src_event) & SRC_MASK; // RL1
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			enable_reg <= '0;
		end else if (reg_wr && reg_addr == OFF_ENABLE0) begin
			enable_reg <= reg_wdata & SRC_MASK; // RL14
		end
	end

	// Priority registers, four fields of three bits each; the gate register has one
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			prio_reg[0] <= PRIO_RST & PRIO0_MASK;
			prio_reg[1] <= PRIO_RST & PRIO1_MASK;
			prio_reg[2] <= PRIO_RST & PRIO2_MASK;
			prio_reg[3] <= PRIO_RST & PRIO3_MASK;
			prio9_reg <= PRIO9_RST;
		end else if (reg_wr) begin
			unique case (reg_addr)
				OFF_PRIO0: prio_reg[0] <= reg_wdata & PRIO0_MASK; // RL3
				OFF_PRIO1: prio_reg[1] <= reg_wdata & PRIO1_MASK; // RL3
				OFF_PRIO2: prio_reg[2] <= reg_wdata & PRIO2_MASK; // RL3
				OFF_PRIO3: prio_reg[3] <= reg_wdata & PRIO3_MASK; // RL3
				OFF_PRIO9: prio9_reg <= reg_wdata & PRIO9_MASK; // RL12
				default: ;
			endcase
		end
	end

	// Source n takes field n of the priority registers, gate source its own
	always_comb begin
		for (int n = 0; n < NSRC; n++) begin
			src_lvl[n] = prio_reg[n / 4][(n % 4) * 4 +: PRIO_W]; // RL7
		end
		src_lvl[GATE_SRC] = prio9_reg[GATE_LSB +: PRIO_W]; // RL12
	end

	// Control registers; trap flags are set by the core, cleared by software
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl1_reg <= '0;
			ctrl2_reg <= '0;
		end else begin
			if (reg_wr && reg_addr == OFF_CTRL1) begin
				ctrl1_reg <= reg_wdata & CTRL1_MASK; // RL10
			end
			if (trap_active) begin
				ctrl1_reg[0] <= 1'b1; // RL10
			end
			if (reg_wr && reg_addr == OFF_CTRL2) begin
				ctrl2_reg <= reg_wdata & CTRL2_MASK; // RL11
			end
		end
	end

	// Core level: three writable status bits and a top bit under hardware
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ipl_reg <= '0;
			ipl_top_reg <= 1'b0;
		end else begin
			ipl_top_reg <= trap_active; // RL9
			if (cpu_ack && state_reg == PRI_PEND && !ctrl1_reg[NEST_DIS_BIT]) begin
				ipl_reg <= lvl_reg[2:0];
			end else if (cpu_ack && state_reg == PRI_PEND) begin
				ipl_reg <= 3'h7; // RL10
			end else if (reg_wr && reg_addr == OFF_STATUS) begin
				ipl_reg <= reg_wdata[IPL_LSB +: 3]; // RL8
			end
		end
	end

	assign cur_lvl = {ipl_top_reg, ipl_reg}; // RL9

	// Candidates: flagged, enabled, nonzero priority, above current level
	always_comb begin
		for (int n = 0; n < NSRC; n++) begin
			cand[n] = flags_reg[n] && enable_reg[n] // RL2
				&& (src_lvl[n] != 3'h0) // RL4
				&& ({1'b0, src_lvl[n]} > cur_lvl); // RL13
		end
	end

	// Linear tournament; lower vector wins ties
	logic lad_vld [0:NSRC];
	logic [2:0] lad_lvl [0:NSRC];
	logic [6:0] lad_vec [0:NSRC];
	assign lad_vld[0] = 1'b0;
	assign lad_lvl[0] = 3'h0;
	assign lad_vec[0] = 7'h00;
	for (genvar g = 0; g < NSRC; g++) begin : g_lad
		pri_prio_cmp u_cmp (
			.a_vld(lad_vld[g]),
			.a_lvl(lad_lvl[g]),
			.a_vec(lad_vec[g]),
			.b_vld(cand[g]),
			.b_lvl(src_lvl[g]),
			.b_vec(7'(g)),
			.w_vld(lad_vld[g+1]),
			.w_lvl(lad_lvl[g+1]),
			.w_vec(lad_vec[g+1])
		);
	end
	assign win_vld = lad_vld[NSRC];
	assign win_lvl = lad_lvl[NSRC];
	assign win_vec = lad_vec[NSRC];

	// Report latch; follows the winner while a vector is offered, held once the core acknowledges
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= PRI_IDLE;
			vec_reg <= '0;
			lvl_reg <= '0;
		end else begin
			unique case (state_reg)
				PRI_IDLE: begin
					if (win_vld) begin
						vec_reg <= win_vec; // RL5
						lvl_reg <= {1'b0, win_lvl}; // RL6
						state_reg <= PRI_PEND;
					end
				end
				PRI_PEND: begin
					if (cpu_ack) begin
						state_reg <= PRI_ACK;
					end else if (!win_vld) begin
						state_reg <= PRI_IDLE;
					end else begin
						vec_reg <= win_vec; // RL5
						lvl_reg <= {1'b0, win_lvl}; // RL6
					end
				end
				PRI_ACK: begin
					if (!cpu_ack) begin
						state_reg <= PRI_IDLE;
					end
				end
			endcase
		end
	end

	// Core outputs, registered
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_req <= 1'b0;
			irq_vec <= '0;
			irq_lvl <= '0;
			alt_vec_sel <= 1'b0;
			ext_edge_sel <= '0;
		end else begin
			irq_req <= (state_reg == PRI_PEND) && win_vld && !cpu_ack; // RL13
			irq_vec <= vec_reg; // RL5
			irq_lvl <= lvl_reg; // RL6
			alt_vec_sel <= ctrl2_reg[ALT_VEC_BIT]; // RL11
			ext_edge_sel <= ctrl2_reg[2:0]; // RL11
		end
	end

	// Event status: new vector offered, and any flag set
	assign ev_set[EV_NEW] = (state_reg == PRI_IDLE) && win_vld;
	assign ev_set[EV_FLAG] = |src_event;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ev_stat_reg <= '0;
			ev_en_reg <= '0;
			irq_out <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == OFF_EVCLR) begin
				ev_stat_reg <= (ev_stat_reg & ~reg_wdata[EV_W-1:0]) | ev_set;
			end else begin
				ev_stat_reg <= ev_stat_reg | ev_set;
			end
			if (reg_wr && reg_addr == OFF_EVEN) begin
				ev_en_reg <= reg_wdata[EV_W-1:0];
			end
			irq_out <= |(ev_stat_reg & ev_en_reg);
		end
	end

	// Read data, one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				OFF_FLAGS0: reg_rdata <= flags_reg; // RL14
				OFF_ENABLE0: reg_rdata <= enable_reg;
				OFF_PRIO0: reg_rdata <= prio_reg[0];
				OFF_PRIO1: reg_rdata <= prio_reg[1];
				OFF_PRIO2: reg_rdata <= prio_reg[2];
				OFF_PRIO3: reg_rdata <= prio_reg[3];
				OFF_PRIO9: reg_rdata <= prio9_reg; // RL12
				OFF_CTRL1: reg_rdata <= ctrl1_reg;
				OFF_CTRL2: reg_rdata <= ctrl2_reg;
				OFF_REPORT: reg_rdata <= {4'h0, lvl_reg, 1'b0, vec_reg}; // RL5
				OFF_STATUS: reg_rdata <= {8'h00, ipl_reg, 5'h00}; // RL8
				OFF_CORCTL: reg_rdata <= {12'h000, ipl_top_reg, 3'h0}; // RL9
				OFF_EVSTAT: reg_rdata <= {14'h0000, ev_stat_reg};
				OFF_EVEN: reg_rdata <= {14'h0000, ev_en_reg};
				default: reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!$past(wr_flags)
		|-> (flags_reg & $past(flags_reg)) == $past(flags_reg)) // RL1
		else $error("flag dropped without software clear");
	a_disabled_hidden: assert property (@(posedge sys_clk) disable iff (!arst_n)
		win_vld |-> enable_reg[win_vec[3:0]]) // RL2
		else $error("disabled source offered");
	a_zero_prio_off: assert property (@(posedge sys_clk) disable iff (!arst_n)
		win_vld |-> win_lvl != 3'h0) // RL4
		else $error("priority zero source offered");
	a_above_level: assert property (@(posedge sys_clk) disable iff (!arst_n)
		win_vld |-> {1'b0, win_lvl} > cur_lvl) // RL13
		else $error("source not above current level");
	a_level_match: assert property (@(posedge sys_clk) disable iff (!arst_n)
		state_reg == PRI_PEND |-> lvl_reg[2:0] == src_lvl[vec_reg[3:0]]) // RL6
		else $error("reported level differs from source priority");
	a_report_out: assert property (@(posedge sys_clk) disable iff (!arst_n)
		##1 irq_vec == $past(vec_reg) && irq_lvl == $past(lvl_reg)) // RL5
		else $error("report outputs lag wrong");
	a_ipl_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
		reg_wr && reg_addr == OFF_STATUS && !cpu_ack
		|=> ipl_reg == $past(reg_wdata[7:5])) // RL8
		else $error("status level write lost");
	a_top_readonly: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!$past(trap_active) |-> !ipl_top_reg) // RL9
		else $error("top level bit set without trap");
	a_gate_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(prio9_reg & ~PRIO9_MASK) == 16'h0000) // RL12
		else $error("gate register stray bits");
	a_unimpl_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
		((flags_reg | enable_reg) & ~SRC_MASK) == 16'h0000) // RL14
		else $error("unimplemented flag bit set");
endmodule

// ---- dv/pri_core_model.sv ----
// Core-side model: takes each offered vector, promptly or after a wait
`timescale 1ns/1ps
module pri_core_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Offer from the controller, and the bench's slow-acknowledge select
	input wire logic irq_req,
	input wire logic slow,
	// Acceptance
	output logic cpu_ack
);
	logic [2:0] wait_reg;
	// Ack lasts one cycle so the offer has dropped before the next look
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cpu_ack <= 1'b0;
			wait_reg <= 3'h0;
		end else if (cpu_ack) begin
			cpu_ack <= 1'b0;
		end else if (irq_req) begin
			if (!slow || wait_reg == 3'h5) begin
				cpu_ack <= 1'b1;
				wait_reg <= 3'h0;
			end else begin
				wait_reg <= wait_reg + 3'h1;
			end
		end
	end
endmodule

// ---- dv/test_prioritized_interrupt_controller.sv ----
// Self-checking bench of the interrupt controller with a core-side model
`timescale 1ns/1ps
module test_prioritized_interrupt_controller;
	import pri_ctl_pkg::*;
	logic sys_clk, arst_n, reg_wr, reg_rd, trap_active, slow, rd_seen;
	logic cpu_ack, irq_req, alt_vec_sel, irq_out;
	logic [4:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, irq_src;
	logic [6:0] irq_vec;
	logic [3:0] irq_lvl;
	logic [2:0] ext_edge_sel, p;
	logic [15:0] rq[$];
	logic [10:0] vq[$];
	int fails, n_compared, cyc, s;
	integer seed;
	int srcs[4] = '{12, 13, 15, 6};

	pri_ctl dut(.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq_src(irq_src), .cpu_ack(cpu_ack),
		.trap_active(trap_active), .irq_req(irq_req), .irq_vec(irq_vec),
		.irq_lvl(irq_lvl), .alt_vec_sel(alt_vec_sel),
		.ext_edge_sel(ext_edge_sel), .irq_out(irq_out));
	pri_core_model core(.sys_clk(sys_clk), .arst_n(arst_n),
		.irq_req(irq_req), .slow(slow), .cpu_ack(cpu_ack));

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task check(input string what, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task print_verdict;
		if (fails == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// Expected read data is queued; the monitor compares it a cycle later
	task rd(input logic [4:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		rq.push_back(exp);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask

	// Flags see a rising edge and settle within three clocks
	task pulse(input logic [15:0] m);
		@(posedge sys_clk);
		irq_src <= irq_src | m;
		repeat (2) @(posedge sys_clk);
		irq_src <= irq_src & ~m;
		repeat (4) @(posedge sys_clk);
	endtask

	task setp(input int k, input logic [2:0] lv);
		wr(5'(OFF_PRIO0 + k / 4), 16'(lv) << (4 * (k % 4)));
	endtask

	// Waits for the offer to be taken, then returns from the handler
	task serve(input int k, input logic [15:0] st);
		int n;
		n = 0;
		while (irq_req !== 1'b1 && n < 40) begin
			@(posedge sys_clk);
			n++;
		end
		check("offer", 16'(irq_req), 16'h1);
		while (irq_req !== 1'b0 && n < 80) begin
			@(posedge sys_clk);
			n++;
		end
		rd(OFF_STATUS, st);
		wr(OFF_FLAGS0, ~(16'h1 << k));
		wr(OFF_STATUS, 16'h0000);
	endtask

	always @(posedge sys_clk) begin
		if (rd_seen) begin
			check("rdata", reg_rdata, rq[0]);
			rq.delete(0);
		end
		rd_seen <= reg_rd;
		if (cpu_ack === 1'b1 && irq_req === 1'b1) begin
			check("vector", 16'(irq_vec), 16'(vq[0][10:4]));
			check("level", 16'(irq_lvl), 16'(vq[0][3:0]));
			vq.delete(0);
		end
		cyc++;
		if (cyc == 20000) begin
			fails++;
			print_verdict();
		end
	end

	initial begin
		seed = 32'hf8d6bc80;
		{reg_wr, reg_rd, trap_active, slow, rd_seen} = 5'h00;
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
		irq_src = 16'h0000;
		arst_n = 1'b0;
		repeat (5) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd(OFF_PRIO2, 16'h4004);
		rd(OFF_PRIO9, PRIO9_RST);
		rd(5'h1F, 16'h0000);
		wr(OFF_PRIO9, 16'hFFFF);
		rd(OFF_PRIO9, 16'h0070);
		wr(OFF_ENABLE0, 16'hFFFF);
		rd(OFF_ENABLE0, SRC_MASK);
		wr(OFF_CTRL2, 16'hFFFF);
		rd(OFF_CTRL2, 16'h8007);
		check("alt", 16'(alt_vec_sel), 16'h1);
		check("edge", 16'(ext_edge_sel), 16'h7);
		wr(OFF_CTRL2, 16'h0000);
		wr(OFF_ENABLE0, 16'h0000);
		// Flags still set with enables off; event interrupt path
		wr(OFF_EVEN, 16'h0002);
		pulse(16'h0800);
		rd(OFF_FLAGS0, 16'h0800);
		check("no offer", 16'(irq_req), 16'h0);
		check("irq_out", 16'(irq_out), 16'h1);
		rd(OFF_EVSTAT, 16'h0002);
		wr(OFF_EVCLR, 16'h0003);
		// Interrupt output lags the status by one clock
		repeat (2) @(posedge sys_clk);
		check("irq_out", 16'(irq_out), 16'h0);
		wr(OFF_EVEN, 16'h0000);
		pulse(16'h1000);
		check("masked", 16'(irq_out), 16'h0);
		wr(OFF_FLAGS0, 16'h0800);
		rd(OFF_FLAGS0, 16'h0800);
		wr(OFF_FLAGS0, 16'h0000);
		// Request zero on falling edge: a rise alone leaves its flag clear
		wr(OFF_CTRL2, 16'h0001);
		irq_src <= 16'h0001;
		repeat (4) @(posedge sys_clk);
		rd(OFF_FLAGS0, 16'h0000);
		irq_src <= 16'h0000;
		repeat (4) @(posedge sys_clk);
		rd(OFF_FLAGS0, 16'h0001);
		wr(OFF_FLAGS0, 16'h0000);
		wr(OFF_CTRL2, 16'h0000);
		// Priority zero keeps an enabled source away
		setp(11, 3'h0);
		wr(OFF_ENABLE0, 16'h0800);
		pulse(16'h0800);
		check("prio0", 16'(irq_req), 16'h0);
		wr(OFF_FLAGS0, 16'h0000);
		// Current level blocks an equal priority
		setp(8, 3'h5);
		wr(OFF_ENABLE0, 16'h0100);
		wr(OFF_STATUS, 16'h00A0);
		rd(OFF_STATUS, 16'h00A0);
		pulse(16'h0100);
		check("blocked", 16'(irq_req), 16'h0);
		vq.push_back({7'd8, 4'd5});
		wr(OFF_STATUS, 16'h0080);
		serve(8, 16'h00A0);
		// Equal priorities: lower vector first
		wr(OFF_PRIO1, 16'h3300);
		wr(OFF_ENABLE0, 16'h00C0);
		vq.push_back({7'd6, 4'd3});
		vq.push_back({7'd7, 4'd3});
		pulse(16'h00C0);
		serve(6, 16'h0060);
		serve(7, 16'h0060);
		// Random levels, prompt and slow acknowledge
		for (int i = 0; i < 4; i++) begin
			p = 3'($unsigned($random(seed)) % 7) + 3'h1;
			s = srcs[i];
			slow <= i[0];
			setp(s, p);
			wr(OFF_ENABLE0, 16'h1 << s);
			vq.push_back({7'(s), 1'b0, p});
			pulse(16'h1 << s);
			// A prompt core takes the offer before a read could start
			serve(s, 16'(p) << 5);
			rd(OFF_REPORT, {5'h00, p, 1'b0, 7'(s)});
		end
		// Nesting disabled raises the level to seven
		wr(OFF_CTRL1, 16'h8000);
		setp(13, 3'h2);
		wr(OFF_ENABLE0, 16'h2000);
		vq.push_back({7'd13, 4'd2});
		pulse(16'h2000);
		serve(13, 16'h00E0);
		wr(OFF_CTRL1, 16'h0000);
		// Trap in progress: top level bit is read-only
		@(posedge sys_clk);
		trap_active <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rd(OFF_CORCTL, 16'h0008);
		wr(OFF_CORCTL, 16'h0000);
		rd(OFF_CORCTL, 16'h0008);
		rd(OFF_CTRL1, 16'h0001);
		trap_active <= 1'b0;
		repeat (3) @(posedge sys_clk);
		print_verdict();
	end
endmodule
